// file: core/alc_cfg.svh
// constants for the ambient light comparator configuration block
`ifndef ALC_CFG_SVH
`define ALC_CFG_SVH
// register offsets
`define ALC_ADDR_SENSOR_ONE 8'h1B
`define ALC_ADDR_SENSOR_TWO 8'h1C
// field positions
`define ALC_FILTER_HI 7
`define ALC_FILTER_LO 5
`define ALC_FORCE_BIT 4
`define ALC_DARK_RES_BIT 3
`define ALC_OFFICE_RES_BIT 2
`define ALC_DARK_EN_BIT 1
`define ALC_OFFICE_EN_BIT 0
// reset values
`define ALC_CFG_RESET 8'h00
`define ALC_RDATA_RESET 8'h00
// timing: shortest filter time and clock rate
`define ALC_FILTER_BASE_MS 80
`define ALC_CLK_KHZ 25000
`define ALC_FILTER_BASE_CYCLES (`ALC_FILTER_BASE_MS * `ALC_CLK_KHZ)
`endif

// file: core/alc_pkg.sv
// types for the ambient light comparator configuration block
package alc_pkg;
  typedef enum logic [2:0] {
    ALC_MODE_DAYLIGHT = 3'b001,
    ALC_MODE_OFFICE = 3'b010,
    ALC_MODE_DARK = 3'b100
  } alc_mode_type;
  typedef enum logic [1:0] {
    ALC_ST_IDLE = 2'b01,
    ALC_ST_CONV = 2'b10
  } alc_state_type;
endpackage

// file: core/alc_channel.sv
// one light sensor channel: comparators, filter window, conversion
`timescale 1ns/1ps
`include "alc_cfg.svh"
module alc_channel
  import alc_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = `ALC_FILTER_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_light,
  input wire logic [7:0] i_office_threshold,
  input wire logic [7:0] i_office_hysteresis,
  input wire logic [7:0] i_dark_threshold,
  input wire logic [2:0] i_filter_time,
  input wire logic i_dark_enable,
  input wire logic i_office_enable,
  input wire logic i_run_continuous,
  input wire logic i_run_forced,
  output logic o_dark_result,
  output logic o_office_result,
  output logic o_done
);
  logic [7:0] light_meta_ff;
  logic [7:0] light_ff;
  logic office_raw_ff;
  logic dark_raw_ff;
  logic [1:0] raw_prev_ff;
  logic [1:0] committed_ff;
  logic [31:0] cnt_ff;
  alc_state_type state_ff;
  alc_state_type nxt_state;
  logic [31:0] nxt_cnt;
  logic nxt_done;

  // filter window length in cycles for a code
  function automatic logic [31:0] filter_cycles(input logic [2:0] code);
    filter_cycles = BASE_CYCLES << code;
  endfunction

  // comparator decisions on the synchronised input
  wire [8:0] office_release = {1'b0, i_office_threshold}
                              + {1'b0, i_office_hysteresis};
  wire office_below = light_ff < i_office_threshold;
  wire office_above = {1'b0, light_ff} > office_release;
  wire dark_below = light_ff < i_dark_threshold;
  wire [1:0] raw_now = {dark_raw_ff, office_raw_ff};
  wire [31:0] limit = filter_cycles(i_filter_time);
  wire start = i_run_continuous | i_run_forced;
  wire window_end = (state_ff == ALC_ST_CONV) && (cnt_ff == limit - 32'd1);

  // two-stage synchroniser and comparator state
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      light_meta_ff <= 8'h00;
      light_ff <= 8'h00;
      office_raw_ff <= 1'b0;
      dark_raw_ff <= 1'b0;
      raw_prev_ff <= 2'h0;
    end else begin
      light_meta_ff <= i_light;
      light_ff <= light_meta_ff;
      if (office_below) begin
        office_raw_ff <= 1'b1;
      end else if (office_above) begin
        office_raw_ff <= 1'b0;
      end
      dark_raw_ff <= dark_below;
      raw_prev_ff <= raw_now;
    end
  end

  // conversion sequencer: result commits after a stable window
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    case (state_ff)
      ALC_ST_IDLE: begin
        nxt_cnt = 32'd0;
        if (start) begin
          nxt_state = ALC_ST_CONV;
        end
      end
      ALC_ST_CONV: begin
        if (!start) begin
          nxt_state = ALC_ST_IDLE;
        end else if (raw_now != raw_prev_ff) begin
          nxt_cnt = 32'd0;
        end else if (window_end) begin
          nxt_done = 1'b1;
          nxt_state = ALC_ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + 32'd1;
        end
      end
      default: begin
        nxt_state = ALC_ST_IDLE;
      end
    endcase
  end

  // state, window count, committed result and gated outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= ALC_ST_IDLE;
      cnt_ff <= 32'd0;
      o_done <= 1'b0;
      committed_ff <= 2'h0;
      o_dark_result <= 1'b0;
      o_office_result <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      o_done <= nxt_done;
      if (nxt_done) begin
        committed_ff <= raw_now;
      end
      o_dark_result <= i_dark_enable & committed_ff[1];
      o_office_result <= i_office_enable & committed_ff[0];
    end
  end

  property p_window_length;
    @(posedge i_clk) disable iff (i_srst)
    o_done |-> $past(cnt_ff) == $past(limit) - 32'd1;
  endproperty
  a_window_length: assert property (p_window_length)
    else $error("conversion ended before filter window");

  property p_office_release;
    @(posedge i_clk) disable iff (i_srst)
    office_above |=> !office_raw_ff;
  endproperty
  a_office_release: assert property (p_office_release)
    else $error("office comparator did not release above hysteresis");

  property p_dark_trip;
    @(posedge i_clk) disable iff (i_srst)
    dark_below |=> dark_raw_ff;
  endproperty
  a_dark_trip: assert property (p_dark_trip)
    else $error("dark comparator did not trip below threshold");

  property p_disabled_dark;
    @(posedge i_clk) disable iff (i_srst)
    !i_dark_enable |=> !o_dark_result;
  endproperty
  a_disabled_dark: assert property (p_disabled_dark)
    else $error("disabled dark comparator reported a result");
endmodule

// file: core/alc_top.sv
// comparator configuration registers for two ambient light sensors
`timescale 1ns/1ps
`include "alc_cfg.svh"
// Notes on behaviour
// - sensor one filter code picks 80 ms doubled per step up to 10240 ms
// - sensor two filter code uses the same 80 ms doubling scale
// - sensor one force bit starts a conversion while backlight is off and sinks are running
// - sensor two force bit starts a conversion while backlight is off and sinks are running
// - force bit clears itself once results are valid
// - force requests are ignored while the backlight is enabled
// - sensor one bit 3 reads dark result, bit 2 office result
// - sensor two bit 3 reads dark result, bit 2 office result
// - sensor one bits 1 and 0 enable dark and office comparators
// - sensor two bits 1 and 0 enable dark and office comparators
// - dark result takes priority over office result
// - office trips below threshold, releases above threshold plus hysteresis
// - dark trips below the dark threshold
module alc_top
  import alc_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = `ALC_FILTER_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_first_light_input,
  input wire logic [7:0] i_second_light_input,
  input wire logic [7:0] i_office_threshold,
  input wire logic [7:0] i_office_hysteresis,
  input wire logic [7:0] i_dark_threshold,
  input wire logic i_backlight_enabled,
  input wire logic i_sinks_running,
  output alc_mode_type o_sensor_one_mode,
  output alc_mode_type o_sensor_two_mode
);
  logic [2:0] sensor_one_filter_time_ff;
  logic sensor_one_force_conversion_ff;
  logic sensor_one_dark_enable_ff;
  logic sensor_one_office_enable_ff;
  logic [2:0] sensor_two_filter_time_ff;
  logic sensor_two_force_conversion_ff;
  logic sensor_two_dark_enable_ff;
  logic sensor_two_office_enable_ff;
  logic sensor_one_dark_result;
  logic sensor_one_office_result;
  logic sensor_two_dark_result;
  logic sensor_two_office_result;
  logic one_done;
  logic two_done;

  // dark wins over office, otherwise daylight
  function automatic alc_mode_type mode_of(input logic dark,
                                           input logic office);
    if (dark) begin
      mode_of = ALC_MODE_DARK;
    end else if (office) begin
      mode_of = ALC_MODE_OFFICE;
    end else begin
      mode_of = ALC_MODE_DAYLIGHT;
    end
  endfunction

  // write decode and force request qualification
  wire wr_one = i_reg_wr && (i_reg_addr == `ALC_ADDR_SENSOR_ONE);
  wire wr_two = i_reg_wr && (i_reg_addr == `ALC_ADDR_SENSOR_TWO);
  wire force_ok = !i_backlight_enabled;
  wire set_one = wr_one && i_reg_wdata[`ALC_FORCE_BIT] && force_ok;
  wire set_two = wr_two && i_reg_wdata[`ALC_FORCE_BIT] && force_ok;
  wire nxt_force_one = set_one | (sensor_one_force_conversion_ff & !one_done);
  wire nxt_force_two = set_two | (sensor_two_force_conversion_ff & !two_done);
  wire run_one = sensor_one_force_conversion_ff & force_ok & i_sinks_running;
  wire run_two = sensor_two_force_conversion_ff & force_ok & i_sinks_running;

  // read-back images; result bits come only from the channels
  wire [7:0] image_one = {sensor_one_filter_time_ff,
                          sensor_one_force_conversion_ff,
                          sensor_one_dark_result,
                          sensor_one_office_result,
                          sensor_one_dark_enable_ff,
                          sensor_one_office_enable_ff};
  wire [7:0] image_two = {sensor_two_filter_time_ff,
                          sensor_two_force_conversion_ff,
                          sensor_two_dark_result,
                          sensor_two_office_result,
                          sensor_two_dark_enable_ff,
                          sensor_two_office_enable_ff};
  wire [7:0] nxt_rdata = (i_reg_addr == `ALC_ADDR_SENSOR_ONE) ? image_one :
                         (i_reg_addr == `ALC_ADDR_SENSOR_TWO) ? image_two :
                         8'h00;

  // sensor one writable fields; set of force wins over self-clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sensor_one_filter_time_ff <= 3'h0;
      sensor_one_dark_enable_ff <= 1'b0;
      sensor_one_office_enable_ff <= 1'b0;
      sensor_one_force_conversion_ff <= 1'b0;
    end else begin
      if (wr_one) begin
        sensor_one_filter_time_ff <=
          i_reg_wdata[`ALC_FILTER_HI:`ALC_FILTER_LO];
        sensor_one_dark_enable_ff <= i_reg_wdata[`ALC_DARK_EN_BIT];
        sensor_one_office_enable_ff <= i_reg_wdata[`ALC_OFFICE_EN_BIT];
      end
      sensor_one_force_conversion_ff <= nxt_force_one;
    end
  end

  // sensor two writable fields
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sensor_two_filter_time_ff <= 3'h0;
      sensor_two_dark_enable_ff <= 1'b0;
      sensor_two_office_enable_ff <= 1'b0;
      sensor_two_force_conversion_ff <= 1'b0;
    end else begin
      if (wr_two) begin
        sensor_two_filter_time_ff <=
          i_reg_wdata[`ALC_FILTER_HI:`ALC_FILTER_LO];
        sensor_two_dark_enable_ff <= i_reg_wdata[`ALC_DARK_EN_BIT];
        sensor_two_office_enable_ff <= i_reg_wdata[`ALC_OFFICE_EN_BIT];
      end
      sensor_two_force_conversion_ff <= nxt_force_two;
    end
  end

  // registered read data and backlight mode outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= `ALC_RDATA_RESET;
      o_sensor_one_mode <= ALC_MODE_DAYLIGHT;
      o_sensor_two_mode <= ALC_MODE_DAYLIGHT;
    end else begin
      o_reg_rdata <= nxt_rdata;
      o_sensor_one_mode <= mode_of(sensor_one_dark_result,
                                   sensor_one_office_result);
      o_sensor_two_mode <= mode_of(sensor_two_dark_result,
                                   sensor_two_office_result);
    end
  end

  // sensor one channel
  alc_channel #(.BASE_CYCLES(BASE_CYCLES)) u_one (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_light(i_first_light_input),
    .i_office_threshold(i_office_threshold),
    .i_office_hysteresis(i_office_hysteresis),
    .i_dark_threshold(i_dark_threshold),
    .i_filter_time(sensor_one_filter_time_ff),
    .i_dark_enable(sensor_one_dark_enable_ff),
    .i_office_enable(sensor_one_office_enable_ff),
    .i_run_continuous(i_backlight_enabled),
    .i_run_forced(run_one),
    .o_dark_result(sensor_one_dark_result),
    .o_office_result(sensor_one_office_result),
    .o_done(one_done)
  );

  // sensor two channel
  alc_channel #(.BASE_CYCLES(BASE_CYCLES)) u_two (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_light(i_second_light_input),
    .i_office_threshold(i_office_threshold),
    .i_office_hysteresis(i_office_hysteresis),
    .i_dark_threshold(i_dark_threshold),
    .i_filter_time(sensor_two_filter_time_ff),
    .i_dark_enable(sensor_two_dark_enable_ff),
    .i_office_enable(sensor_two_office_enable_ff),
    .i_run_continuous(i_backlight_enabled),
    .i_run_forced(run_two),
    .o_dark_result(sensor_two_dark_result),
    .o_office_result(sensor_two_office_result),
    .o_done(two_done)
  );

  property p_force_ignored;
    @(posedge i_clk) disable iff (i_srst)
    (i_backlight_enabled && !sensor_one_force_conversion_ff && wr_one)
      |=> !sensor_one_force_conversion_ff;
  endproperty
  a_force_ignored: assert property (p_force_ignored)
    else $error("force accepted while backlight enabled");

  property p_force_set_one;
    @(posedge i_clk) disable iff (i_srst)
    (wr_one && i_reg_wdata[`ALC_FORCE_BIT] && !i_backlight_enabled)
      |=> sensor_one_force_conversion_ff;
  endproperty
  a_force_set_one: assert property (p_force_set_one)
    else $error("sensor one force bit not set");

  property p_force_set_two;
    @(posedge i_clk) disable iff (i_srst)
    (wr_two && i_reg_wdata[`ALC_FORCE_BIT] && !i_backlight_enabled)
      |=> sensor_two_force_conversion_ff;
  endproperty
  a_force_set_two: assert property (p_force_set_two)
    else $error("sensor two force bit not set");

  property p_force_clear;
    @(posedge i_clk) disable iff (i_srst)
    (one_done && !set_one) |=> !sensor_one_force_conversion_ff;
  endproperty
  a_force_clear: assert property (p_force_clear)
    else $error("force bit not cleared after conversion");

  property p_readback_one;
    @(posedge i_clk) disable iff (i_srst)
    (i_reg_addr == `ALC_ADDR_SENSOR_ONE) |=>
      o_reg_rdata[3:2] == $past({sensor_one_dark_result,
                                 sensor_one_office_result});
  endproperty
  a_readback_one: assert property (p_readback_one)
    else $error("sensor one result bits read back wrong");

  property p_readback_two;
    @(posedge i_clk) disable iff (i_srst)
    (i_reg_addr == `ALC_ADDR_SENSOR_TWO) |=>
      o_reg_rdata[3:2] == $past({sensor_two_dark_result,
                                 sensor_two_office_result});
  endproperty
  a_readback_two: assert property (p_readback_two)
    else $error("sensor two result bits read back wrong");

  property p_dark_priority;
    @(posedge i_clk) disable iff (i_srst)
    (sensor_one_dark_result && sensor_one_office_result)
      |=> o_sensor_one_mode == ALC_MODE_DARK;
  endproperty
  a_dark_priority: assert property (p_dark_priority)
    else $error("office result overrode dark result");

  property p_result_readonly;
    @(posedge i_clk) disable iff (i_srst)
    (wr_one && sensor_one_dark_enable_ff && !one_done && !$past(one_done))
      |=> $stable(sensor_one_dark_result) || !sensor_one_dark_enable_ff;
  endproperty
  a_result_readonly: assert property (p_result_readonly)
    else $error("host write changed a result bit");

  property p_enable_two;
    @(posedge i_clk) disable iff (i_srst)
    !sensor_two_office_enable_ff |=> !sensor_two_office_result;
  endproperty
  a_enable_two: assert property (p_enable_two)
    else $error("disabled office comparator reported a result");
endmodule

// file: bench/alc_sensor_model.sv
// photosensor model giving two digitised light codes
`timescale 1ns/1ps
module alc_sensor_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [7:0] i_target_one,
  input wire logic [7:0] i_target_two,
  output logic [7:0] o_light_one,
  output logic [7:0] o_light_two
);
  // a slow sensor creeps one code per cycle toward the target
  function automatic logic [7:0] step(logic [7:0] c, logic [7:0] t);
    if (c < t) return c + 8'h01;
    if (c > t) return c - 8'h01;
    return c;
  endfunction
  // bright light first, then settle at once or ramp toward the target
  initial begin
    o_light_one = 8'hFF;
    o_light_two = 8'hFF;
    forever begin
      @(posedge i_clk);
      o_light_one <= i_slow ? step(o_light_one, i_target_one) : i_target_one;
      o_light_two <= i_slow ? step(o_light_two, i_target_two) : i_target_two;
    end
  end
endmodule

// file: bench/alc_tb.sv
// self-checking bench for the light comparator registers
`timescale 1ns/1ps
module tb;
  import alc_pkg::*;
  localparam int unsigned BASE = 4;
  logic i_clk, i_srst, i_reg_wr, i_backlight_enabled, i_sinks_running;
  logic [7:0] i_reg_addr, i_reg_wdata, i_office_threshold;
  logic [7:0] i_office_hysteresis, i_dark_threshold, tgt;
  logic slow, rd_req, rd_stage;
  wire logic [7:0] o_reg_rdata, light_one, light_two;
  alc_mode_type mode_one, mode_two;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // table: light code, enables, dark/office bits, mode
  logic [7:0] t_light[7] = '{8'h82, 8'h46, 8'h6E, 8'h1E, 8'h6E, 8'h7D, 8'h1E};
  logic [1:0] t_en[7] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1};
  logic [1:0] t_bits[7] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h1, 2'h0, 2'h1};
  alc_mode_type t_mode[7] = '{ALC_MODE_DAYLIGHT, ALC_MODE_OFFICE,
    ALC_MODE_OFFICE, ALC_MODE_DARK, ALC_MODE_OFFICE, ALC_MODE_DAYLIGHT,
    ALC_MODE_OFFICE};

  alc_sensor_model sensors (.i_clk(i_clk), .i_slow(slow),
    .i_target_one(tgt), .i_target_two(tgt),
    .o_light_one(light_one), .o_light_two(light_two));

  alc_top #(.BASE_CYCLES(BASE)) uut (.i_clk(i_clk), .i_srst(i_srst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_first_light_input(light_one), .i_second_light_input(light_two),
    .i_office_threshold(i_office_threshold),
    .i_office_hysteresis(i_office_hysteresis),
    .i_dark_threshold(i_dark_threshold),
    .i_backlight_enabled(i_backlight_enabled),
    .i_sinks_running(i_sinks_running),
    .o_sensor_one_mode(mode_one), .o_sensor_two_mode(mode_two));

  // clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [15:0] e);
    checks_done++;
    if ((got & e[15:8]) !== (e[7:0] & e[15:8])) begin
      num_errors++;
      $display("ERROR %0t read %h want %h mask %h", $time, got, e[7:0],
               e[15:8]);
    end
  endtask

  task automatic cmp_mode(input alc_mode_type got, input alc_mode_type e);
    checks_done++;
    if (got !== e) begin
      num_errors++;
      $display("ERROR %0t mode %b want %b", $time, got, e);
    end
  endtask

  task automatic cmp_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %0t took %0d cycles, want %0d..%0d", $time, got, lo,
               hi);
    end
  endtask

  // monitor: read data lands one cycle after the address
  always @(posedge i_clk) begin
    rd_stage <= rd_req;
    cyc <= cyc + 1;
  end
  always @(negedge i_clk) begin
    if (rd_stage) begin
      cmp_byte(o_reg_rdata, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #2 i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clk);
    #2 i_reg_wr = 1'b0;
  endtask

  // one read; with chk set the expected byte is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic chk,
                    input logic [7:0] e, input logic [7:0] m,
                    output logic [7:0] q);
    @(posedge i_clk);
    #2 i_reg_addr = a;
    rd_req = chk;
    if (chk) exp_q.push_back({m, e});
    @(posedge i_clk);
    #2 rd_req = 1'b0;
    q = o_reg_rdata;
  endtask

  // forced conversion, polled until the force bit drops
  task automatic conv(input logic [7:0] a, input logic [7:0] cfg,
                      output int n);
    logic [7:0] q;
    int c0;
    wr(a, cfg | 8'h10);
    c0 = cyc;
    do begin
      rd(a, 1'b0, 8'h00, 8'h00, q);
    end while (q[4] === 1'b1 && cyc - c0 < 3000);
    n = cyc - c0;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #(40 * 60000);
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    logic [7:0] a, d, q;
    int n, w;
    void'($urandom(32'h1277));
    i_srst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_office_threshold = 8'h64;
    i_office_hysteresis = 8'h14;
    i_dark_threshold = 8'h28;
    i_backlight_enabled = 1'b0;
    i_sinks_running = 1'b1;
    tgt = 8'hC8;
    slow = 1'b0;
    rd_req = 1'b0;
    repeat (4) @(posedge i_clk);
    #2 i_srst = 1'b0;
    // reset state, unmapped address reads zero
    rd(8'h1B, 1'b1, 8'h00, 8'hFF, q);
    rd(8'h1C, 1'b1, 8'h00, 8'hFF, q);
    rd(8'h1D, 1'b1, 8'h00, 8'hFF, q);
    cmp_mode(mode_one, ALC_MODE_DAYLIGHT);
    cmp_mode(mode_two, ALC_MODE_DAYLIGHT);
    // random config, result bits written high must read back low
    for (int i = 0; i < 6; i++) begin
      a = i[0] ? 8'h1C : 8'h1B;
      d = 8'($urandom) | 8'h0C;
      d[4] = 1'b0;
      wr(a, d);
      wr(8'h1D, 8'hFF);
      rd(a, 1'b1, d & 8'hF3, 8'hFF, q);
    end
    // every filter code on both sensors, window doubles per step
    for (int c = 0; c < 8; c++) begin
      for (int ch = 0; ch < 2; ch++) begin
        a = ch[0] ? 8'h1C : 8'h1B;
        w = BASE << c;
        conv(a, {3'(c), 5'b00011}, n);
        cmp_range(n, w, w + 10);
        rd(a, 1'b1, {3'(c), 5'b00011}, 8'hFF, q);
      end
    end
    // comparator levels, hysteresis and dark priority
    slow = 1'b1;
    for (int r = 0; r < 7; r++) begin
      tgt = t_light[r];
      repeat (300) @(posedge i_clk);
      #2;
      for (int ch = 0; ch < 2; ch++) begin
        a = ch[0] ? 8'h1C : 8'h1B;
        conv(a, {6'h00, t_en[r]}, n);
        repeat (3) @(posedge i_clk);
        rd(a, 1'b1, {4'h0, t_bits[r], t_en[r]}, 8'hFF, q);
      end
      cmp_mode(mode_one, t_mode[r]);
      cmp_mode(mode_two, t_mode[r]);
    end
    // backlight on: force refused, continuous conversion tracks light
    i_backlight_enabled = 1'b1;
    wr(8'h1B, 8'h13);
    rd(8'h1B, 1'b1, 8'h03, 8'hF3, q);
    wr(8'h1C, 8'h13);
    rd(8'h1C, 1'b1, 8'h03, 8'hF3, q);
    tgt = 8'h82;
    repeat (400) @(posedge i_clk);
    rd(8'h1B, 1'b1, 8'h03, 8'hFF, q);
    cmp_mode(mode_one, ALC_MODE_DAYLIGHT);
    i_backlight_enabled = 1'b0;
    // sinks stopped: forced conversion waits
    i_sinks_running = 1'b0;
    tgt = 8'h1E;
    repeat (300) @(posedge i_clk);
    wr(8'h1B, 8'h13);
    repeat (40) @(posedge i_clk);
    rd(8'h1B, 1'b1, 8'h10, 8'h10, q);
    i_sinks_running = 1'b1;
    repeat (40) @(posedge i_clk);
    rd(8'h1B, 1'b1, 8'h0F, 8'hFF, q);
    cmp_mode(mode_one, ALC_MODE_DARK);
    // reset in mid-run
    i_srst = 1'b1;
    @(posedge i_clk);
    #2 i_srst = 1'b0;
    rd(8'h1B, 1'b1, 8'h00, 8'hFF, q);
    cmp_mode(mode_one, ALC_MODE_DAYLIGHT);
    repeat (4) @(posedge i_clk);
    wrap_up();
  end
endmodule
